/* File: spp_pkg.sv */
// Shared constants and types of the serial peripheral port
package spp_pkg;
  localparam int SPP_NSEL = 4;
  localparam int SPP_DW = 16;
  localparam int SPP_FIFO_DEPTH = 8;
  localparam logic [3:0] SPP_PCS_NONE = 4'hf;
  localparam logic [4:0] SPP_BITS_MIN = 5'h08;
  localparam logic [4:0] SPP_BITS_MAX = 5'h10;
  localparam logic [3:0] SPP_BITS_TOP = 4'h8;
  localparam logic [7:0] SPP_SCBR_MIN = 8'h02;
  localparam logic [7:0] SPP_DLY_MIN = 8'h01;

  // Per-select transfer settings
  typedef struct packed {
    logic [3:0] bits;
    logic cpol;
    logic ncpha;
    logic [7:0] scbr;
    logic [7:0] select_to_clock_delay;
    logic [7:0] between_transfers_delay;
  } spp_csr_t;

  // One data word with its select pattern
  typedef struct packed {
    logic [3:0] peripheral_select_field;
    logic [15:0] data;
  } spp_word_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SELD = 3'h1,
    ST_XFER = 3'h3,
    ST_DLYC = 3'h2,
    ST_SLV = 3'h6
  } spp_state_t;
endpackage : spp_pkg

/* File: spp_slave_model.sv */
// Behavioural slave peripheral that faces the port in master role
`timescale 1ns/1ps
`default_nettype none
module spp_slave_model (
  // Serial pins
  input wire logic sck_in,
  input wire logic mosi_in,
  input wire logic [3:0] sel_in,
  output logic miso_out,
  // Bench side
  input wire logic [4:0] nbits_in,
  input wire logic [15:0] tx_in,
  output logic [15:0] rx_out,
  output logic [3:0] sel_out,
  output int edges_out,
  output time t_sel_out,
  output time t_clk_out
);
  logic [15:0] sh = 16'h0;
  logic idle_v = 1'b0;
  wire act = (sel_in != 4'hf);
  // Reply bit while selected; the inverted last bit once released, as nothing holds the line
  assign miso_out = act ? sh[15] : idle_v;
  // A new selection loads the reply word, MSB of the word length first
  always @(act) begin
    if (act) begin
      sh = tx_in << (5'h10 - nbits_in);
      rx_out = 16'h0;
      edges_out = 0;
      sel_out = sel_in;
      t_sel_out = $time;
    end else begin
      idle_v = ~sh[15];
    end
  end
  // Capture on the rising edge
  always @(posedge sck_in) begin
    if (act) begin
      if (edges_out == 0) t_clk_out = $time;
      rx_out = {rx_out[14:0], mosi_in};
      edges_out++;
    end
  end
  // Shift on the falling edge; reload after each whole word
  always @(negedge sck_in) begin
    if (act && edges_out % int'(nbits_in) == 0) sh = tx_in << (5'h10 - nbits_in);
    else if (act) sh = sh << 1;
  end
endmodule : spp_slave_model
`default_nettype wire

/* File: spp_top.sv */
// Serial peripheral port, master and slave, with transmit FIFO
//
// Summary of operation
// - Port works as master or as slave
// - Four select lines encode up to fifteen devices
// - Word length programmable from 8 to 16
// - Transmit and receive handshakes serve memory channels
// - Master drives out-line; slave drives in-line
// - Clock pin driven as master, input as slave
// - Select zero: output, fault input, slave select
// - Master drives selects and clock per transfer
// - Enabled master starts when transmit word written
// - Separate transmit and receive buffering
// - Waiting transmit word for the same select continues transfer directly
// - Unread receive word overwritten sets overrun
// - Per-select delay from select to clock
// - Per-select delay between consecutive transfers
// - Settings come from active select's config
// - Fixed selection keeps one peripheral
// - Variable selection may change peripheral per word
// - Mode bit clear: select from mode field
// - Mode bit set: select from each word
// - Mode fault flags, holds, disables until enabled
// - Slave waits for select low before clocking
`timescale 1ns/1ps
`default_nettype none

// Transmit FIFO with registered input ready
module spp_fifo #(
  parameter int W = 20,
  parameter int D = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Fill side
  input wire logic in_valid_in,
  input wire logic [W-1:0] in_data_in,
  output logic in_ready_out,
  // Drain side
  output logic out_valid_out,
  output logic [W-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r, cnt_nxt;
  wire push = in_valid_in & in_ready_out;
  wire pop = out_valid_out & out_ready_in;

  // Occupancy and flags
  assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  assign out_valid_out = (cnt_r != '0);
  assign out_data_out = mem[rp_r];

  // Pointers and ready flag
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      in_ready_out <= 1'b0;
    end else begin
      if (push) wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
      if (pop) rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_nxt;
      in_ready_out <= (cnt_nxt != (AW+1)'(D));
    end
  end

  // Storage
  always_ff @(posedge clk_in) begin
    if (push) mem[wp_r] <= in_data_in;
  end
endmodule : spp_fifo

module spp_top #(
  parameter int FIFO_DEPTH = spp_pkg::SPP_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  // Role and selection
  input wire logic MASTER_IN,
  input wire logic PERIPHERAL_SELECT_MODE_BIT_IN,
  input wire logic PCS_DECODE_IN,
  input wire logic [3:0] PERIPHERAL_SELECT_FIELD_IN,
  input wire spp_pkg::spp_csr_t [3:0] CSR_IN,
  // Commands and status
  input wire logic PORT_ENABLE_COMMAND_IN,
  input wire logic DISABLE_IN,
  input wire logic STATUS_RD_IN,
  input wire logic OVR_MASK_IN,
  output logic ENABLED_OUT,
  output logic MODE_FAULT_FLAG_OUT,
  output logic RECEIVE_OVERRUN_FLAG_OUT,
  output logic OVR_IRQ_OUT,
  // Transmit words
  input wire logic TX_VALID_IN,
  input wire spp_pkg::spp_word_t TX_WORD_IN,
  output logic TX_READY_OUT,
  // Receive words
  output logic RX_VALID_OUT,
  output spp_pkg::spp_word_t RX_WORD_OUT,
  input wire logic RX_READY_IN,
  // Serial pins
  input wire logic SERIAL_CLOCK_PIN_IN,
  output logic SERIAL_CLOCK_PIN_OUT,
  output logic SERIAL_CLOCK_PIN_OE_OUT,
  input wire logic MOSI_IN,
  output logic MOSI_OUT,
  output logic MOSI_OE_OUT,
  input wire logic MISO_IN,
  output logic MISO_OUT,
  output logic MISO_OE_OUT,
  input wire logic SELECT_ZERO_OR_SLAVE_SELECT_IN,
  output logic SELECT_ZERO_OR_SLAVE_SELECT_OUT,
  output logic SELECT_ZERO_OR_SLAVE_SELECT_OE_OUT,
  output logic [2:0] PERIPHERAL_SELECT_OUTPUTS_UPPER_OUT
);
  import spp_pkg::*;

  // Word length from the bits field, clamped at sixteen
  function automatic logic [4:0] nbits(input logic [3:0] b);
    nbits = (b > SPP_BITS_TOP) ? SPP_BITS_MAX : SPP_BITS_MIN + {1'b0, b};
  endfunction : nbits

  // Config index of a select pattern
  function automatic logic [1:0] sel_idx(input logic [3:0] p, input logic dec);
    if (dec) sel_idx = p[3:2];
    else if (!p[0]) sel_idx = 2'h0;
    else if (!p[1]) sel_idx = 2'h1;
    else if (!p[2]) sel_idx = 2'h2;
    else sel_idx = 2'h3;
  endfunction : sel_idx

  // Delay count, at least one cycle
  function automatic logic [7:0] dly(input logic [7:0] v, input logic [7:0] lo);
    dly = ((v < lo) ? lo : v) - 8'h01;
  endfunction : dly

  logic rst_s1_r, rst_n;
  logic [3:0] sy1_r, sy2_r;
  logic sck_d_r;
  spp_state_t st_r, st_nxt;
  logic en_r, mode_fault_flag_r, ovr_r, irq_r;
  logic rx_vld_r;
  spp_word_t rx_word_r;
  logic [15:0] sh_r;
  logic dout_r, sck_r;
  logic [3:0] npcs_r, npcs_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [5:0] ecnt_r, ecnt_nxt;
  logic [1:0] cur_r, cur_nxt;
  logic sck_oe_r, mosi_oe_r, miso_oe_r, cs0_oe_r;
  logic cs0_h1_r, cs0_h2_r;
  logic ld;
  logic f_vld;
  spp_word_t f_word;

  // Reset release through two flip-flops
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  // Pin synchronisers: clock, out-line, in-line, slave select
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      sy1_r <= 4'hf;
      sy2_r <= 4'hf;
      sck_d_r <= 1'b1;
    end else begin
      sy1_r <= {SELECT_ZERO_OR_SLAVE_SELECT_IN, MISO_IN, MOSI_IN, SERIAL_CLOCK_PIN_IN};
      sy2_r <= sy1_r;
      sck_d_r <= sy2_r[0];
    end
  end

  wire sck_s = sy2_r[0];
  wire mosi_s = sy2_r[1];
  wire miso_s = sy2_r[2];
  wire nss_s = sy2_r[3];

  // Transmit buffer; ready doubles as the memory channel request
  spp_fifo #(.W($bits(spp_word_t)), .D(FIFO_DEPTH)) u_txf (
    .clk_in(CLK_IN),
    .rst_n_in(rst_n),
    .in_valid_in(TX_VALID_IN),
    .in_data_in(TX_WORD_IN),
    .in_ready_out(TX_READY_OUT),
    .out_valid_out(f_vld),
    .out_data_out(f_word),
    .out_ready_in(ld)
  );

  // Role, selection and active settings
  wire mst_go = en_r & MASTER_IN;
  wire slv_go = en_r & ~MASTER_IN & ~nss_s;
  wire m_busy = MASTER_IN & (st_r != ST_IDLE) & (st_r != ST_SLV);
  wire [3:0] new_pcs = PERIPHERAL_SELECT_MODE_BIT_IN ? f_word.peripheral_select_field
                                                     : PERIPHERAL_SELECT_FIELD_IN;
  wire [1:0] new_idx = sel_idx(new_pcs, PCS_DECODE_IN);
  wire [1:0] ld_idx = MASTER_IN ? new_idx : 2'h0;
  spp_csr_t csr, ld_csr;
  assign csr = CSR_IN[cur_r];
  assign ld_csr = CSR_IN[ld_idx];
  wire [4:0] nb = nbits(csr.bits);
  wire [4:0] ld_nb = nbits(ld_csr.bits);
  wire [15:0] ld_dat = f_vld ? f_word.data : 16'h0000;
  wire [15:0] ld_aln = ld_dat << (5'h10 - ld_nb);
  wire [7:0] hp = dly(csr.scbr, SPP_SCBR_MIN);

  // Mode fault: someone else pulls select zero low while master
  // Our own release takes two cycles through the synchroniser, so the pin must have been high that long
  wire fault = mst_go & ~nss_s & npcs_r[0] & cs0_h2_r;

  // Edge generation and detection
  wire m_edge = (st_r == ST_XFER) & (cnt_r == 8'h00) & (ecnt_r != {nb, 1'b0});
  wire done_m = (st_r == ST_XFER) & (cnt_r == 8'h00) & (ecnt_r == {nb, 1'b0});
  wire s_edge = (st_r == ST_SLV) & slv_go & (sck_s ^ sck_d_r);
  wire done_s = s_edge & (ecnt_r == {nb, 1'b0} - 6'h01);
  wire edge_ev = m_edge | s_edge;
  wire lead = ~ecnt_r[0];
  wire cap = edge_ev & (lead == csr.ncpha);
  wire chg = edge_ev & ~cap;
  wire in_bit = MASTER_IN ? miso_s : mosi_s;
  wire [15:0] sh_cap = cap ? {sh_r[14:0], in_bit} : sh_r;
  wire [15:0] rx_mask = 16'hffff >> (5'h10 - nb);
  wire done = done_m | done_s;
  wire same_dev = (new_pcs == npcs_r);
  wire ovr_ev = done & rx_vld_r & ~RX_READY_IN;

  // Sequencer
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    ecnt_nxt = edge_ev ? ecnt_r + 6'h01 : ecnt_r;
    npcs_nxt = npcs_r;
    cur_nxt = cur_r;
    ld = 1'b0;
    case (st_r)
      ST_IDLE: begin
        if (mst_go & f_vld & ~fault) begin
          st_nxt = ST_SELD;
          ld = 1'b1;
          npcs_nxt = new_pcs;
          cur_nxt = ld_idx;
          cnt_nxt = dly(ld_csr.select_to_clock_delay, SPP_DLY_MIN);
        end else if (slv_go) begin
          st_nxt = ST_SLV;
          ld = 1'b1;
          cur_nxt = 2'h0;
          ecnt_nxt = 6'h00;
        end
      end
      ST_SELD: begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h00) begin
          st_nxt = ST_XFER;
          cnt_nxt = hp;
          ecnt_nxt = 6'h00;
        end
      end
      ST_XFER: begin
        cnt_nxt = (cnt_r == 8'h00) ? hp : cnt_r - 8'h01;
        if (done_m) begin
          st_nxt = ST_DLYC;
          cnt_nxt = dly(csr.between_transfers_delay, SPP_DLY_MIN);
        end
      end
      ST_DLYC: begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h00) begin
          if (mst_go & f_vld & same_dev) begin
            st_nxt = ST_XFER;
            ld = 1'b1;
            cnt_nxt = hp;
            ecnt_nxt = 6'h00;
          end else begin
            st_nxt = ST_IDLE;
            npcs_nxt = SPP_PCS_NONE;
          end
        end
      end
      ST_SLV: begin
        if (!slv_go) begin
          st_nxt = ST_IDLE;
        end else if (done_s) begin
          ld = 1'b1;
          ecnt_nxt = 6'h00;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
        npcs_nxt = SPP_PCS_NONE;
      end
    endcase
    if (fault) begin
      st_nxt = ST_IDLE;
      npcs_nxt = SPP_PCS_NONE;
      ld = 1'b0;
    end
  end

  // State, counters and selects
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
      cnt_r <= 8'h00;
      ecnt_r <= 6'h00;
      npcs_r <= SPP_PCS_NONE;
      cur_r <= 2'h0;
      cs0_h1_r <= 1'b1;
      cs0_h2_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      ecnt_r <= ecnt_nxt;
      npcs_r <= npcs_nxt;
      cur_r <= cur_nxt;
      cs0_h1_r <= npcs_r[0];
      cs0_h2_r <= cs0_h1_r;
    end
  end

  // Shifter, data out and serial clock
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      sh_r <= 16'h0000;
      dout_r <= 1'b0;
      sck_r <= 1'b0;
    end else begin
      sh_r <= ld ? ld_aln : sh_cap;
      dout_r <= ld ? ld_aln[15] : (chg ? sh_r[15] : dout_r);
      if (ld && st_r == ST_IDLE) sck_r <= ld_csr.cpol;
      else if (m_edge) sck_r <= ~sck_r;
    end
  end

  // Enable, flags and receive register; set wins over clear, except disable and mode fault win over enable
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      en_r <= 1'b0;
      mode_fault_flag_r <= 1'b0;
      ovr_r <= 1'b0;
      irq_r <= 1'b0;
      rx_vld_r <= 1'b0;
      rx_word_r <= '0;
    end else begin
      en_r <= ~DISABLE_IN & ~fault & (PORT_ENABLE_COMMAND_IN | en_r);
      mode_fault_flag_r <= fault | (mode_fault_flag_r & ~STATUS_RD_IN);
      ovr_r <= ovr_ev | (ovr_r & ~STATUS_RD_IN);
      irq_r <= ovr_r & OVR_MASK_IN;
      rx_vld_r <= done | (rx_vld_r & ~RX_READY_IN);
      if (done) rx_word_r <= {npcs_r, sh_cap & rx_mask};
    end
  end

  // Pin drive enables by role
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      sck_oe_r <= 1'b0;
      mosi_oe_r <= 1'b0;
      miso_oe_r <= 1'b0;
      cs0_oe_r <= 1'b0;
    end else begin
      sck_oe_r <= (mst_go & ~fault) | m_busy;
      mosi_oe_r <= (mst_go & ~fault) | m_busy;
      miso_oe_r <= slv_go;
      cs0_oe_r <= (mst_go & ~fault) | m_busy;
    end
  end

  // Outputs
  assign ENABLED_OUT = en_r;
  assign MODE_FAULT_FLAG_OUT = mode_fault_flag_r;
  assign RECEIVE_OVERRUN_FLAG_OUT = ovr_r;
  assign OVR_IRQ_OUT = irq_r;
  assign RX_VALID_OUT = rx_vld_r;
  assign RX_WORD_OUT = rx_word_r;
  assign SERIAL_CLOCK_PIN_OUT = sck_r;
  assign SERIAL_CLOCK_PIN_OE_OUT = sck_oe_r;
  assign MOSI_OUT = dout_r;
  assign MOSI_OE_OUT = mosi_oe_r;
  assign MISO_OUT = dout_r;
  assign MISO_OE_OUT = miso_oe_r;
  assign SELECT_ZERO_OR_SLAVE_SELECT_OUT = npcs_r[0];
  assign SELECT_ZERO_OR_SLAVE_SELECT_OE_OUT = cs0_oe_r;
  assign PERIPHERAL_SELECT_OUTPUTS_UPPER_OUT = npcs_r[3:1];

  // Checks
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!rst_n);

  sequence seq_sel_start;
    st_r == ST_IDLE ##1 st_r == ST_SELD;
  endsequence
  sequence seq_xfer_end;
    st_r == ST_XFER ##1 st_r == ST_DLYC;
  endsequence

  mode_fault_flag_stop_a: assert property ($rose(mode_fault_flag_r) |-> !en_r && st_r == ST_IDLE)
    else $error("mode fault left port enabled");
  ovr_set_a: assert property (ovr_ev |=> ovr_r && rx_vld_r)
    else $error("overrun not flagged");
  ovr_hold_a: assert property (ovr_r && !STATUS_RD_IN |=> ovr_r)
    else $error("overrun cleared without status read");
  role_excl_a: assert property (MISO_OE_OUT |-> !MOSI_OE_OUT && !SERIAL_CLOCK_PIN_OE_OUT)
    else $error("both data lines driven");
  cs_delay_a: assert property (seq_sel_start |=> $stable(sck_r)[*2])
    else $error("clock moved too early after select");
  start_write_a: assert property (st_r == ST_IDLE && mst_go && f_vld && !fault |=> st_r == ST_SELD)
    else $error("master did not start on pending word");
  cont_direct_a: assert property (st_r == ST_DLYC && cnt_r == 8'h00 && mst_go && f_vld && same_dev && !fault
                                  |=> st_r == ST_XFER)
    else $error("waiting word did not continue");
  fixed_sel_a: assert property (seq_sel_start ##0 !$past(PERIPHERAL_SELECT_MODE_BIT_IN)
                                |-> npcs_r == $past(PERIPHERAL_SELECT_FIELD_IN))
    else $error("fixed select not from mode field");
  var_sel_a: assert property (seq_sel_start ##0 $past(PERIPHERAL_SELECT_MODE_BIT_IN)
                              |-> npcs_r == $past(f_word.peripheral_select_field))
    else $error("variable select not from word");
  word_len_a: assert property (seq_xfer_end |-> $past(ecnt_r) == {nb, 1'b0} && nb >= 5'h08 && nb <= 5'h10)
    else $error("wrong number of clock edges");
  slave_wait_a: assert property (!MASTER_IN && nss_s |=> st_r != ST_SLV)
    else $error("slave active without select");
endmodule : spp_top

`default_nettype wire

/* File: tb_serial_peripheral_port_master_slave.sv */
// Self-checking bench of the serial peripheral port
`timescale 1ns/1ps
`default_nettype none
module tb_serial_peripheral_port_master_slave;
  import spp_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, master = 1'b1, psm = 1'b0, en = 1'b0, dis = 1'b0, srd = 1'b0;
  logic mask = 1'b1, txv = 1'b0, rxr = 1'b1, tb_sck = 1'b0, tb_mosi = 1'b0, tb_ss = 1'b1;
  logic [3:0] pcsf = 4'he;
  spp_csr_t [3:0] csr;
  spp_word_t txw = '0, rxw;
  logic ena, mf, ovr, irq, txr, rxv, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe, m_miso;
  logic [2:0] up;
  logic [15:0] m_rx, stx = 16'h0, d, r;
  logic [4:0] nb = 5'h08;
  logic [3:0] m_sel;
  int m_edges, i, errors = 0, tests_run = 0;
  time t_sel, t_clk;
  logic [15:0] expq[$];
  integer seed = 32'hb5f2;
  // Pin levels from all drivers; select zero is open drain with a pull-up
  wire sck_w = sck_oe ? sck_o : tb_sck;
  wire mosi_w = mosi_oe ? mosi_o : tb_mosi;
  wire miso_w = miso_oe ? miso_o : m_miso;
  wire ss_w = (ss_oe ? ss_o : 1'b1) & tb_ss;
  wire act = ({up, ss_w} != 4'hf);

  spp_top DUT (.CLK_IN(clk), .RST_B_IN(rst_b), .MASTER_IN(master), .PERIPHERAL_SELECT_MODE_BIT_IN(psm),
    .PCS_DECODE_IN(1'b0), .PERIPHERAL_SELECT_FIELD_IN(pcsf), .CSR_IN(csr), .PORT_ENABLE_COMMAND_IN(en),
    .DISABLE_IN(dis), .STATUS_RD_IN(srd), .OVR_MASK_IN(mask), .ENABLED_OUT(ena), .MODE_FAULT_FLAG_OUT(mf),
    .RECEIVE_OVERRUN_FLAG_OUT(ovr), .OVR_IRQ_OUT(irq), .TX_VALID_IN(txv), .TX_WORD_IN(txw),
    .TX_READY_OUT(txr), .RX_VALID_OUT(rxv), .RX_WORD_OUT(rxw), .RX_READY_IN(rxr),
    .SERIAL_CLOCK_PIN_IN(sck_w), .SERIAL_CLOCK_PIN_OUT(sck_o), .SERIAL_CLOCK_PIN_OE_OUT(sck_oe),
    .MOSI_IN(mosi_w), .MOSI_OUT(mosi_o), .MOSI_OE_OUT(mosi_oe), .MISO_IN(miso_w), .MISO_OUT(miso_o),
    .MISO_OE_OUT(miso_oe), .SELECT_ZERO_OR_SLAVE_SELECT_IN(ss_w), .SELECT_ZERO_OR_SLAVE_SELECT_OUT(ss_o),
    .SELECT_ZERO_OR_SLAVE_SELECT_OE_OUT(ss_oe), .PERIPHERAL_SELECT_OUTPUTS_UPPER_OUT(up));

  spp_slave_model PEER (.sck_in(sck_w), .mosi_in(mosi_w), .sel_in({up, ss_w}), .miso_out(m_miso),
    .nbits_in(nb), .tx_in(stx), .rx_out(m_rx), .sel_out(m_sel), .edges_out(m_edges),
    .t_sel_out(t_sel), .t_clk_out(t_clk));

  // System clock
  initial begin
    forever #2 clk = ~clk;
  end

  task automatic summarize();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // One-cycle pulse of enable, disable or status read
  task automatic cmd(input logic [2:0] k);
    {en, dis, srd} <= k;
    tick(1);
    {en, dis, srd} <= 3'h0;
    tick(1);
  endtask : cmd

  // Offers a word and holds it until the FIFO takes it
  task automatic push(input spp_word_t w);
    txv <= 1'b1;
    txw <= w;
    for (i = 0; i < 2000; i++) begin
      @(negedge clk);
      if (txr === 1'b1) break;
    end
    if (i >= 2000) begin
      errors++;
      summarize();
    end
    @(posedge clk);
  endtask : push

  // Waits for one selection to open and close again
  task automatic wdone();
    for (i = 0; i < 4000 && !act; i++) @(posedge clk);
    if (i < 4000) for (i = 0; i < 4000 && act; i++) @(posedge clk);
    if (i >= 4000) begin
      errors++;
      summarize();
    end
    tick(4);
  endtask : wdone

  // Receive watcher: each word read off the port meets the oldest note
  always @(posedge clk) begin
    if (rxv === 1'b1 && rxr) begin
      if (expq.size() == 0) chk(1, 0, "unexpected word");
      else chk(rxw.data, expq.pop_front(), "received word");
    end
  end

  // Main sequence
  initial begin
    csr[0] = '{4'h0, 1'b0, 1'b1, 8'h04, 8'h14, 8'h03};
    csr[1] = '{4'h8, 1'b0, 1'b1, 8'h04, 8'h02, 8'h02};
    csr[2] = csr[0];
    csr[3] = csr[0];
    tick(11);
    @(negedge clk);
    chk({up, ss_o, txr}, 5'h1e, "reset selects");
    chk({sck_oe, mosi_oe, miso_oe}, 3'h0, "reset drivers");
    @(posedge clk);
    rst_b <= 1'b1;
    tick(4);
    cmd(3'h4);
    chk(ena, 1, "enabled");
    // Fixed selection, 8-bit words, select-to-clock delay
    stx <= 16'($random(seed));
    d = 16'($random(seed));
    tick(1);
    expq.push_back({8'h00, stx[7:0]});
    push('{4'h7, d});
    txv <= 1'b0;
    wdone();
    chk(m_sel, 4'he, "fixed select");
    chk(m_rx[7:0], d[7:0], "slave got");
    chk(m_edges, 8, "bit count");
    chk((t_clk - t_sel) / 4 inside {[20:25]}, 1, "select delay");
    // Variable selection picks config one and 16-bit words
    psm <= 1'b1;
    nb <= 5'h10;
    stx <= 16'($random(seed));
    d = 16'($random(seed));
    tick(1);
    expq.push_back(stx);
    push('{4'hd, d});
    txv <= 1'b0;
    wdone();
    chk(m_sel, 4'hd, "word select");
    chk(m_rx, d, "slave got wide");
    chk(m_edges, 16, "wide count");
    // Fill the FIFO while disabled, then burst with the reader stalled
    psm <= 1'b0;
    nb <= 5'h08;
    cmd(3'h6);
    chk(ena, 0, "disable wins");
    for (int k = 0; k < 8; k++) push('{4'h0, 16'($random(seed))});
    txv <= 1'b0;
    tick(2);
    txv <= 1'b1;
    tick(3);
    @(negedge clk);
    chk(txr, 0, "fifo full");
    @(posedge clk);
    txv <= 1'b0;
    rxr <= 1'b0;
    expq.push_back({8'h00, stx[7:0]});
    cmd(3'h4);
    wdone();
    chk(m_edges, 64, "burst unbroken");
    chk({ovr, irq}, 2'h3, "overrun");
    rxr <= 1'b1;
    tick(3);
    cmd(3'h1);
    tick(2);
    chk({ovr, irq}, 2'h0, "status read");
    // Another master pulls select zero low
    tb_ss <= 1'b0;
    tick(8);
    chk({mf, ena}, 2'h2, "mode fault");
    tb_ss <= 1'b1;
    tick(8);
    chk(ena, 0, "stays off");
    cmd(3'h1);
    chk(mf, 0, "fault cleared");
    // Slave role driven at the 48 ns link clock
    master <= 1'b0;
    d = 16'($random(seed));
    push('{4'hf, {8'h00, d[7:0]}});
    txv <= 1'b0;
    cmd(3'h4);
    tb_ss <= 1'b0;
    tick(12);
    stx = 16'($random(seed));
    expq.push_back({8'h00, stx[7:0]});
    for (int b = 7; b >= 0; b--) begin
      tb_mosi <= stx[b];
      tick(5);
      @(negedge clk);
      r[b] = miso_w;
      @(posedge clk);
      tb_sck <= 1'b1;
      tick(6);
      tb_sck <= 1'b0;
    end
    // Last clock edge must cross the synchroniser while still selected
    tick(6);
    chk({sck_oe, miso_oe, mosi_oe}, 3'h2, "slave drivers");
    tb_ss <= 1'b1;
    tick(12);
    chk(r[7:0], d[7:0], "slave sent");
    chk(expq.size(), 0, "all words seen");
    summarize();
  end
endmodule : tb_serial_peripheral_port_master_slave
`default_nettype wire
